/* include/ifp_pkg.sv */
// Constants for the interrupt flag, enable and priority register block.
// Assumes a Wishbone classic slave with 32-bit data, registers in the low 16 bits.
package ifp_pkg;

   // Register byte offsets
   localparam logic [7:0] IFP_OFS_CTRL2 = 8'h00;
   localparam logic [7:0] IFP_OFS_FLAGS2 = 8'h04;
   localparam logic [7:0] IFP_OFS_FLAGS3 = 8'h08;
   localparam logic [7:0] IFP_OFS_EN5 = 8'h0C;
   localparam logic [7:0] IFP_OFS_EN6 = 8'h10;
   localparam logic [7:0] IFP_OFS_PRIO0 = 8'h14;
   localparam logic [7:0] IFP_OFS_EVENT = 8'h18;

   // Field positions
   localparam int IFP_BIT_ALT_VT = 15;
   localparam int IFP_BIT_IRQ_DISABLE_ACTIVE = 14;
   localparam int IFP_BIT_EP2 = 2;
   localparam int IFP_BIT_EP1 = 1;
   localparam int IFP_BIT_EP0 = 0;
   localparam int IFP_BIT_CCT5 = 9;
   localparam int IFP_BIT_CAL = 14;
   localparam int IFP_BIT_BCL2 = 2;
   localparam int IFP_BIT_SSP2 = 1;
   localparam int IFP_BIT_ULPW = 0;
   localparam int IFP_BIT_CLC2 = 1;
   localparam int IFP_BIT_CLC1 = 0;
   localparam int IFP_POS_T1P = 12;
   localparam int IFP_POS_CC2P = 8;
   localparam int IFP_POS_CC1P = 4;
   localparam int IFP_POS_EX0P = 0;

   // Implemented bit masks
   localparam logic [15:0] IFP_MASK_CTRL2 = 16'hC007;
   localparam logic [15:0] IFP_MASK_CTRL2_WR = 16'h8007;
   localparam logic [15:0] IFP_MASK_FLAGS2 = 16'h0200;
   localparam logic [15:0] IFP_MASK_FLAGS3 = 16'h4006;
   localparam logic [15:0] IFP_MASK_EN5 = 16'h0001;
   localparam logic [15:0] IFP_MASK_EN6 = 16'h0003;
   localparam logic [15:0] IFP_MASK_PRIO0 = 16'h7777;

   // Reset values
   localparam logic [15:0] IFP_RST_ZERO = 16'h0000;
   localparam logic [15:0] IFP_RST_PRIO0 = 16'h4444;
   localparam logic [2:0] IFP_PRIO_OFF = 3'h0;

endpackage : ifp_pkg

/* hw/ifp_edge_det.sv */
// Synchroniser and selectable-polarity edge detector for one external input.
// Assumes the input pin is asynchronous to clk_i.
`timescale 1ns/1ps
module ifp_edge_det (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Pin and select
   input wire logic pin_i,
   input wire logic falling_i,
   // Detected edge
   output logic edge_o
);
   logic sync1_reg;
   logic sync2_reg;
   logic last_reg;

   // No reset: the chain tracks the pin through reset, so an idle-high pin gives no false edge
   always_ff @(posedge clk_i) begin
      sync1_reg <= pin_i;
      sync2_reg <= sync1_reg;
      last_reg <= sync2_reg;
   end

   // Polarity one picks the falling edge; nothing is reported while reset is held
   assign edge_o = ~rst_i & (falling_i ? (last_reg & ~sync2_reg) : (~last_reg & sync2_reg));
endmodule // ifp_edge_det

/* hw/ifp_prio_sel.sv */
// Picks the highest enabled pending source among four priority fields.
// Assumes pending bits and fields come from the same clock domain.
`timescale 1ns/1ps
module ifp_prio_sel (
   // Sources
   input wire logic [3:0] pend_i,
   input wire logic [11:0] prio_i,
   // Winner
   output logic valid_o,
   output logic [1:0] idx_o,
   output logic [2:0] level_o
);
   import ifp_pkg::*;
   logic [2:0] lvl;

   always_comb begin
      lvl = IFP_PRIO_OFF;
      valid_o = 1'b0;
      idx_o = 2'd0;
      level_o = IFP_PRIO_OFF;
      for (int i = 0; i < 4; i++) begin
         lvl = prio_i[i*3 +: 3];
         // Level zero never competes; ties go to the lower index
         if (pend_i[i] && lvl != IFP_PRIO_OFF && lvl > level_o) begin
            valid_o = 1'b1;
            idx_o = 2'(i);
            level_o = lvl;
         end
      end
   end
endmodule // ifp_prio_sel

/* hw/ifp_top.sv */
// Interrupt control, flag, enable and priority registers on a Wishbone slave.
// Assumes request lines are single-cycle pulses on clk_i, external inputs are pins.
`timescale 1ns/1ps
module ifp_top (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone classic slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // External interrupt pins
   input wire logic [2:0] ext_pin_i,
   // Peripheral request pulses
   input wire logic capcomp5_timer_req_i,
   input wire logic calendar_req_i,
   input wire logic serial2_collision_req_i,
   input wire logic serial2_event_req_i,
   input wire logic lowpower_wake_req_i,
   input wire logic logic_cell2_req_i,
   input wire logic logic_cell1_req_i,
   input wire logic timer1_req_i,
   input wire logic capcomp2_req_i,
   input wire logic capcomp1_req_i,
   // Core status
   input wire logic irq_disable_active_i,
   // Core side outputs
   output logic alt_vector_table_select_o,
   output logic [2:0] ext_edge_o,
   output logic [2:0] gated_req_o,
   output logic irq_valid_o,
   output logic [1:0] irq_idx_o,
   output logic [2:0] irq_level_o
);
   import ifp_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   logic [15:0] ctrl2_reg;
   logic [15:0] flags2_reg;
   logic [15:0] flags3_reg;
   logic [15:0] en5_reg;
   logic [15:0] en6_reg;
   logic [15:0] prio0_reg;
   logic [3:0] pend_reg;
   logic irq_disable_active_reg;
   logic ack_reg;
   logic [31:0] dat_reg;
   logic [2:0] edge_det;
   logic [15:0] wr_data;
   logic wr_stb;
   logic rd_stb;
   logic [3:0] pend_set;
   logic [3:0] pend_clr;

   assign wr_stb = cyc_i & stb_i & we_i & ~ack_reg;
   assign rd_stb = cyc_i & stb_i & ~we_i & ~ack_reg;

   // Merge write data with current value under byte enables
   function automatic logic [15:0] ifp_merge(input logic [15:0] cur, input logic [15:0] wd,
                                             input logic [3:0] sel);
      logic [15:0] r;
      r = cur;
      if (sel[0]) r[7:0] = wd[7:0];
      if (sel[1]) r[15:8] = wd[15:8];
      return r;
   endfunction

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      return a == ofs;
   endfunction

   assign wr_data = dat_i[15:0];

   ////////////////////////////////////////////////////////////////////////////
   // External edge detectors
   for (genvar g = 0; g < 3; g++) begin : g_ext
      ifp_edge_det u_edge (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .pin_i(ext_pin_i[g]),
         .falling_i(ctrl2_reg[g]),
         .edge_o(edge_det[g])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl2_reg <= IFP_RST_ZERO;
      end else if (wr_stb && hit(adr_i, IFP_OFS_CTRL2)) begin
         ctrl2_reg <= ifp_merge(ctrl2_reg, wr_data, sel_i) & IFP_MASK_CTRL2_WR;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_disable_active_reg <= 1'b0;
      end else begin
         irq_disable_active_reg <= irq_disable_active_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Flag registers: hardware set wins over a software clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flags2_reg <= IFP_RST_ZERO;
      end else begin
         if (wr_stb && hit(adr_i, IFP_OFS_FLAGS2)) begin
            flags2_reg <= ifp_merge(flags2_reg, wr_data, sel_i) & IFP_MASK_FLAGS2;
         end
         if (capcomp5_timer_req_i) begin
            flags2_reg[IFP_BIT_CCT5] <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flags3_reg <= IFP_RST_ZERO;
      end else begin
         if (wr_stb && hit(adr_i, IFP_OFS_FLAGS3)) begin
            flags3_reg <= ifp_merge(flags3_reg, wr_data, sel_i) & IFP_MASK_FLAGS3;
         end
         if (calendar_req_i) begin
            flags3_reg[IFP_BIT_CAL] <= 1'b1;
         end
         if (serial2_collision_req_i) begin
            flags3_reg[IFP_BIT_BCL2] <= 1'b1;
         end
         if (serial2_event_req_i) begin
            flags3_reg[IFP_BIT_SSP2] <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Enable registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         en5_reg <= IFP_RST_ZERO;
      end else if (wr_stb && hit(adr_i, IFP_OFS_EN5)) begin
         en5_reg <= ifp_merge(en5_reg, wr_data, sel_i) & IFP_MASK_EN5;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         en6_reg <= IFP_RST_ZERO;
      end else if (wr_stb && hit(adr_i, IFP_OFS_EN6)) begin
         en6_reg <= ifp_merge(en6_reg, wr_data, sel_i) & IFP_MASK_EN6;
      end
   end

   // Enabled requests reach the core; zero blocks
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gated_req_o <= 3'b000;
      end else begin
         gated_req_o[0] <= lowpower_wake_req_i & en5_reg[IFP_BIT_ULPW];
         gated_req_o[1] <= logic_cell1_req_i & en6_reg[IFP_BIT_CLC1];
         gated_req_o[2] <= logic_cell2_req_i & en6_reg[IFP_BIT_CLC2];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Priority register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prio0_reg <= IFP_RST_PRIO0;
      end else if (wr_stb && hit(adr_i, IFP_OFS_PRIO0)) begin
         prio0_reg <= ifp_merge(prio0_reg, wr_data, sel_i) & IFP_MASK_PRIO0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pending sources arbitrated by priority: 0 ext0, 1 cc1, 2 cc2, 3 timer1
   assign pend_set = {timer1_req_i, capcomp2_req_i, capcomp1_req_i, edge_det[0]};
   assign pend_clr = (wr_stb && hit(adr_i, IFP_OFS_EVENT) && sel_i[0]) ? dat_i[3:0] : 4'h0;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pend_reg <= 4'h0;
      end else begin
         pend_reg <= (pend_reg & ~pend_clr) | pend_set;
      end
   end

   ifp_prio_sel u_sel (
      .pend_i(pend_reg),
      .prio_i({prio0_reg[IFP_POS_T1P +: 3], prio0_reg[IFP_POS_CC2P +: 3],
               prio0_reg[IFP_POS_CC1P +: 3], prio0_reg[IFP_POS_EX0P +: 3]}),
      .valid_o(irq_valid_o),
      .idx_o(irq_idx_o),
      .level_o(irq_level_o)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Core outputs
   assign alt_vector_table_select_o = ctrl2_reg[IFP_BIT_ALT_VT];
   assign ext_edge_o = edge_det;

   ////////////////////////////////////////////////////////////////////////////
   // Wishbone answer: ack one cycle after strobe, unmapped reads zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= cyc_i & stb_i & ~ack_reg;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_reg <= 32'h0000_0000;
      end else if (rd_stb) begin
         case (adr_i)
            IFP_OFS_CTRL2: dat_reg <= {16'h0000, (ctrl2_reg | (16'(irq_disable_active_reg) << IFP_BIT_IRQ_DISABLE_ACTIVE))
                                      & IFP_MASK_CTRL2};
            IFP_OFS_FLAGS2: dat_reg <= {16'h0000, flags2_reg};
            IFP_OFS_FLAGS3: dat_reg <= {16'h0000, flags3_reg};
            IFP_OFS_EN5: dat_reg <= {16'h0000, en5_reg};
            IFP_OFS_EN6: dat_reg <= {16'h0000, en6_reg};
            IFP_OFS_PRIO0: dat_reg <= {16'h0000, prio0_reg};
            IFP_OFS_EVENT: dat_reg <= {28'h000_0000, pend_reg};
            default: dat_reg <= 32'h0000_0000;
         endcase
      end
   end

   assign ack_o = ack_reg;
   assign dat_o = dat_reg;
endmodule // ifp_top

/* test/ifp_periph_model.sv */
// Peripheral request sources on the far side of the flag block.
// Assumes the bench asks for a request by holding one fire bit for one cycle.
`timescale 1ns/1ps
module ifp_periph_model (
   // Clock
   input wire logic clk_i,
   // Bench command
   input wire logic [9:0] fire_i,
   // Request pulses
   output logic [9:0] req_o
);
   // One-cycle pulse per command, launched from the clock edge
   always_ff @(posedge clk_i) begin
      req_o <= fire_i;
   end
endmodule // ifp_periph_model

/* test/ifp_asserts.sv */
// Concurrent checks on the ports of the flag, enable and priority block.
// Assumes a classic Wishbone master that holds its request until ack.
`timescale 1ns/1ps
module ifp_asserts (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Bus
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   // Requests and status
   input wire logic lowpower_wake_req_i,
   input wire logic irq_disable_active_i,
   input wire logic alt_vector_table_select_o,
   input wire logic [2:0] gated_req_o,
   input wire logic irq_valid_o,
   input wire logic [2:0] irq_level_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_take; cyc_i && stb_i && !ack_o; endsequence
   sequence s_rd_ctrl; ack_o && !we_i && adr_i == 8'h00; endsequence
   property p_ack; s_take |=> ack_o; endproperty
   property p_pulse; ack_o |=> !ack_o; endproperty
   property p_upper; ack_o |-> dat_o[31:16] == 16'h0000; endproperty
   property p_unmap; ack_o && !we_i && adr_i > 8'h18 |-> dat_o == 32'h0000_0000; endproperty
   property p_ctrl; s_rd_ctrl |-> dat_o[13:3] == 11'h000; endproperty
   property p_irq_disable_active; s_rd_ctrl |-> dat_o[14] == $past(irq_disable_active_i, 2); endproperty
   property p_alt; ack_o && we_i && adr_i == 8'h00 && sel_i[1] |=> alt_vector_table_select_o == $past(dat_i[15]);
   endproperty
   property p_gate; gated_req_o[0] |-> $past(lowpower_wake_req_i); endproperty
   property p_level; irq_valid_o |-> irq_level_o != 3'h0; endproperty
   property p_rst; $fell(rst_i) |-> !alt_vector_table_select_o && gated_req_o == 3'h0; endproperty
   a_ack: assert property (p_ack) else $error("no ack one cycle after request");
   a_pulse: assert property (p_pulse) else $error("ack longer than one cycle");
   a_upper: assert property (p_upper) else $error("upper read half not zero");
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   a_ctrl: assert property (p_ctrl) else $error("control gap bits not zero");
   a_irq_disable_active: assert property (p_irq_disable_active) else $error("disable status wrong");
   a_alt: assert property (p_alt) else $error("vector table select wrong");
   a_gate: assert property (p_gate) else $error("wake request passed without cause");
   a_level: assert property (p_level) else $error("level zero won");
   a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
endmodule // ifp_asserts
bind ifp_top ifp_asserts ifp_asserts_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
   .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .lowpower_wake_req_i(lowpower_wake_req_i),
   .irq_disable_active_i(irq_disable_active_i), .alt_vector_table_select_o(alt_vector_table_select_o),
   .gated_req_o(gated_req_o), .irq_valid_o(irq_valid_o), .irq_level_o(irq_level_o));

/* test/tb_interrupt_flag_enable_priority.sv */
// Self-checking bench for the flag, enable and priority block.
// Assumes the peripheral model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module tb_interrupt_flag_enable_priority;
   import ifp_pkg::*;
   logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, irqd, alt, ivld;
   logic [7:0] adr_i;
   logic [3:0] sel_i;
   logic [31:0] dat_i, dat_o, q;
   logic [2:0] pin, edg, gq, lvl;
   logic [1:0] idx;
   logic [9:0] fire, req;
   int error_cnt = 0, n_compared = 0;
   ifp_periph_model ifp_periph_model_i (.clk_i(clk_i), .fire_i(fire), .req_o(req));
   ifp_top ifp_top_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
      .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .ext_pin_i(pin), .capcomp5_timer_req_i(req[0]),
      .calendar_req_i(req[1]), .serial2_collision_req_i(req[2]), .serial2_event_req_i(req[3]),
      .lowpower_wake_req_i(req[4]), .logic_cell2_req_i(req[5]), .logic_cell1_req_i(req[6]), .timer1_req_i(req[7]),
      .capcomp2_req_i(req[8]), .capcomp1_req_i(req[9]), .irq_disable_active_i(irqd),
      .alt_vector_table_select_o(alt), .ext_edge_o(edg), .gated_req_o(gq), .irq_valid_o(ivld), .irq_idx_o(idx),
      .irq_level_o(lvl));
   ////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wb(input logic [7:0] a, input logic w, input logic [15:0] d);
      cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; sel_i <= 4'h3; dat_i <= {16'h0000, d};
      do begin
         @(posedge clk_i);
      end while (ack_o !== 1'b1);
      q = dat_o;
      cyc_i <= 1'b0; stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
      wb(a, 1'b0, 16'h0000);
      chk($sformatf("reg %h", a), {16'h0000, e}, q);
   endtask
   // Pulse request lines, then gather gated and edge outputs
   task automatic pulse(input logic [9:0] f, output logic [2:0] g, output logic [2:0] x);
      g = 3'h0; x = 3'h0;
      fire <= f;
      @(posedge clk_i);
      fire <= 10'h000;
      repeat (6) begin
         @(posedge clk_i);
         g = g | gq; x = x | edg;
      end
   endtask
   ////////////////////////////////////////////////////////////
   task automatic t_regs();
      logic [7:0] ofs[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
      logic [15:0] msk[6] = '{16'h8007, 16'h0200, 16'h4006, 16'h0001, 16'h0003, 16'h7777};
      for (int i = 0; i < 6; i++) rdchk(ofs[i], i == 5 ? 16'h4444 : 16'h0000);
      for (int i = 0; i < 6; i++) begin
         wb(ofs[i], 1'b1, 16'hFFFF);
         rdchk(ofs[i], msk[i]);
         wb(ofs[i], 1'b1, 16'h0000);
      end
      wb(8'h1C, 1'b1, 16'hFFFF);
      rdchk(8'h1C, 16'h0000);
      irqd <= 1'b1;
      wb(8'h00, 1'b1, 16'h0000);
      rdchk(8'h00, 16'h4000);
      irqd <= 1'b0;
   endtask
   task automatic t_flags();
      logic [2:0] g, x;
      pulse(10'h00F, g, x);
      rdchk(8'h04, 16'h0200);
      rdchk(8'h08, 16'h4006);
      pulse(10'h070, g, x);
      chk("gated off", 32'h0, {29'h0, g});
      wb(8'h0C, 1'b1, 16'h0001);
      wb(8'h10, 1'b1, 16'h0003);
      pulse(10'h070, g, x);
      chk("gated on", 32'h7, {29'h0, g});
   endtask
   task automatic t_prio();
      logic [2:0] g, x;
      wb(8'h14, 1'b1, 16'h2550);
      pulse(10'h380, g, x);
      chk("win tie", 32'h0000_002D, {26'h0, ivld, idx, lvl});
      wb(8'h14, 1'b1, 16'h2500);
      chk("win next", 32'h0000_0035, {26'h0, ivld, idx, lvl});
      wb(8'h14, 1'b1, 16'h0000);
      chk("all off", 32'h0, {31'h0, ivld});
      wb(8'h18, 1'b1, 16'h000F);
   endtask
   task automatic t_edge();
      logic [2:0] g, x;
      for (int i = 0; i < 3; i++) begin
         wb(8'h00, 1'b1, 16'h0000);
         pin[i] <= 1'b1;
         pulse(10'h000, g, x);
         chk("rise", 32'h1 << i, {29'h0, x});
         wb(8'h00, 1'b1, 16'h0001 << i);
         pin[i] <= 1'b0;
         pulse(10'h000, g, x);
         chk("fall", 32'h1 << i, {29'h0, x});
         pin[i] <= 1'b1;
         pulse(10'h000, g, x);
         chk("rise blocked", 32'h0, {29'h0, x});
      end
   endtask
   task automatic tally_and_finish();
      if (error_cnt == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   initial begin
      repeat (5000) @(posedge clk_i);
      error_cnt++;
      tally_and_finish();
   end
   initial begin
      rst_i = 1'b1; cyc_i = 1'b0; stb_i = 1'b0; we_i = 1'b0; adr_i = 8'h00; sel_i = 4'h0;
      dat_i = 32'h0000_0000; pin = 3'h0; irqd = 1'b0; fire = 10'h000;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_regs();
      t_flags();
      t_prio();
      t_edge();
      tally_and_finish();
   end
endmodule // tb_interrupt_flag_enable_priority
